// File: pmrs_pkg.sv
package pmrs_pkg;

    // ==========================================================
    // power modes
    typedef enum logic [2:0] {
        PM_ACTIVE,
        PM_IDLE,
        PM_SLEEP,
        PM_PDS,
        PM_EXTENDED_POWER_DOWN_SLEEP,
        PM_OFF
    } pmrs_mode_e;

    // ==========================================================
    // sizes
    localparam int GPIO_N      = 20;
    localparam int GPIO_IDX_W  = 5;
    localparam int TMR_W       = 32;
    localparam int CLK_N       = 8;

    // ==========================================================
    // timing, from 250 MHz system clock
    localparam int CLK_PERIOD_NS   = 4;
    localparam int BUCK_SETTLE_NS  = 1000;
    localparam int BUCK_CYC = (BUCK_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W           = 16;

    // ==========================================================
    // wake cause encoding
    localparam logic [1:0] CAUSE_NONE  = 2'h0;
    localparam logic [1:0] CAUSE_TIMER = 2'h1;
    localparam logic [1:0] CAUSE_GPIO  = 2'h2;

    typedef struct packed {
        logic                  fromOff;
        logic [1:0]            cause;
        logic [GPIO_IDX_W-1:0] gpioIdx;
    } pmrs_wake_s;

    typedef struct packed {
        logic cpuRun;
        logic busClkOn;
        logic coreOn;
        logic radioOn;
        logic regsOn;
        logic ramOn;
        logic ldoLow;
        logic lpoOn;
    } pmrs_dom_s;

endpackage

// File: pmrs_wake_ret.sv
// retained wake-cause store, powered with the gpio domain
module pmrs_wake_ret (
    input  wire logic               clk,
    input  wire logic               porRst,
    input  wire logic               wr,
    input  wire pmrs_pkg::pmrs_wake_s wd,
    input  wire logic               clr,
    output pmrs_pkg::pmrs_wake_s    rd
);
    pmrs_pkg::pmrs_wake_s mem_q;

    always_ff @(posedge clk) begin
        if (porRst) begin
            mem_q <= '0;
        end else if (wr) begin
            mem_q <= wd;
        end else if (clr) begin
            mem_q <= '0;
        end
    end

    assign rd = mem_q;
endmodule

// File: pmrs_sequencer.sv
module pmrs_sequencer (
    input  wire logic                          clk,
    input  wire logic                          sys_rst,
    input  wire logic                          external_reset_n,
    input  wire logic                          brownout,
    input  wire logic                          ldoRfStable,
    input  wire logic                          ldoDigStable,
    input  wire logic                          lpoExtClkSel,
    input  wire logic                          lpoTick,
    input  wire logic                          modeReqValid,
    input  wire pmrs_pkg::pmrs_mode_e          modeReq,
    input  wire logic                          offTimedWake,
    input  wire logic [pmrs_pkg::TMR_W-1:0]    wakeInterval,
    input  wire logic                          wait_for_interrupt_state,
    input  wire logic [pmrs_pkg::GPIO_N-1:0]   gpioWake,
    input  wire logic [pmrs_pkg::CLK_N-1:0]    clkGateOk,
    input  wire logic                          initDone,
    input  wire logic                          wakeCauseClr,
    output logic                               buckEn,
    output logic                               ldoRfEn,
    output logic                               ldoDigEn,
    output logic                               coreRst,
    output logic                               shutdown,
    output logic                               cpuHalt,
    output logic                               busClkEn,
    output logic [pmrs_pkg::CLK_N-1:0]         clkEn,
    output logic                               radioPwr,
    output logic                               corePwr,
    output logic                               regsPwr,
    output logic                               ramPwr,
    output logic                               ldoLowV,
    output logic                               lpoPwr,
    output logic                               lpoXtalSel,
    output pmrs_pkg::pmrs_mode_e               curMode,
    output logic                               inInit,
    output pmrs_pkg::pmrs_wake_s               wakeCause
);
    // ==========================================================
    // power-up sequence states
    typedef enum logic [2:0] {
        SQ_OFF,
        SQ_BUCK,
        SQ_LDO,
        SQ_RUN,
        SQ_SHUT
    } pmrs_seq_e;

    pmrs_seq_e                  seq_q, seq_d;
    pmrs_pkg::pmrs_mode_e       mode_q, mode_d;
    pmrs_pkg::pmrs_mode_e       pend_q;
    logic                       pendV_q;
    logic                       timed_q;
    logic                       init_q;
    logic [pmrs_pkg::CNT_W-1:0] cnt_q;
    logic [pmrs_pkg::TMR_W-1:0] tmr_q;
    logic [pmrs_pkg::TMR_W-1:0] ivl_q;
    pmrs_pkg::pmrs_dom_s        dom_q, dom_d;
    logic [pmrs_pkg::CLK_N-1:0] clkEn_q;

    // ==========================================================
    // reset sources
    wire hardRst = sys_rst | ~external_reset_n;
    wire bo      = brownout;

    // ==========================================================
    // wake detection
    wire lowMode  = (mode_q == pmrs_pkg::PM_SLEEP) | (mode_q == pmrs_pkg::PM_PDS)
                  | (mode_q == pmrs_pkg::PM_EXTENDED_POWER_DOWN_SLEEP) | (mode_q == pmrs_pkg::PM_OFF);
    wire tmrArmed = lowMode & (mode_q != pmrs_pkg::PM_OFF | timed_q);
    wire tmrHit   = tmrArmed & lpoTick & (tmr_q >= ivl_q);
    wire gpioHit  = lowMode & (|gpioWake);
    wire wakeHit  = tmrHit | gpioHit;
    wire wakeIdle = (mode_q == pmrs_pkg::PM_IDLE) & (|gpioWake);

    logic [pmrs_pkg::GPIO_IDX_W-1:0] gpioIdx;
    always_comb begin
        gpioIdx = '0;
        for (int i = pmrs_pkg::GPIO_N - 1; i >= 0; i--) begin
            if (gpioWake[i]) begin
                gpioIdx = i[pmrs_pkg::GPIO_IDX_W-1:0];
            end
        end
    end

    // gpio wins a tie so the recorded pin is never lost
    pmrs_pkg::pmrs_wake_s wakeRec;
    assign wakeRec.fromOff = (mode_q == pmrs_pkg::PM_OFF);
    assign wakeRec.cause   = gpioHit ? pmrs_pkg::CAUSE_GPIO : pmrs_pkg::CAUSE_TIMER;
    assign wakeRec.gpioIdx = gpioHit ? gpioIdx : '0;

    wire retWr = wakeHit & (seq_q == SQ_RUN);

    // cause survives external reset; only sys_rst, a brownout or firmware clear drops it
    pmrs_wake_ret u_ret (
        .clk    (clk),
        .porRst (sys_rst | bo),
        .wr     (retWr),
        .wd     (wakeRec),
        .clr    (wakeCauseClr),
        .rd     (wakeCause)
    );

    // ==========================================================
    // mode request: only latched from firmware, applied on wfi
    wire reqTake = modeReqValid & (seq_q == SQ_RUN) & ~init_q;
    wire applyNow = (pendV_q | reqTake) & wait_for_interrupt_state & ~lowMode;
    wire pmrs_pkg::pmrs_mode_e nextReq = reqTake ? modeReq : pend_q;

    // ==========================================================
    // power-up sequencer
    wire cntDone = (cnt_q >= pmrs_pkg::CNT_W'(pmrs_pkg::BUCK_CYC));
    wire offWake = wakeHit & (mode_q == pmrs_pkg::PM_OFF);

    always_comb begin
        seq_d = seq_q;
        case (seq_q)
            SQ_OFF:  seq_d = SQ_BUCK;
            SQ_BUCK: if (cntDone) begin
                seq_d = SQ_LDO;
            end
            SQ_LDO:  if (ldoRfStable & ldoDigStable) begin
                seq_d = SQ_RUN;
            end
            SQ_RUN:  if (offWake) begin
                seq_d = SQ_OFF;
            end
            SQ_SHUT: seq_d = SQ_SHUT;
            default: seq_d = SQ_OFF;
        endcase
        if (bo) begin
            seq_d = SQ_SHUT;
        end
    end

    always_comb begin
        mode_d = mode_q;
        if (seq_q != SQ_RUN) begin
            mode_d = pmrs_pkg::PM_ACTIVE;
        end else if (wakeHit) begin
            mode_d = pmrs_pkg::PM_ACTIVE;
        end else if (wakeIdle) begin
            mode_d = pmrs_pkg::PM_ACTIVE;
        end else if (applyNow) begin
            mode_d = nextReq;
        end
    end

    // ==========================================================
    // domains kept up in each mode except off, written by field name so that
    // a bit moved in the struct cannot silently power the wrong domain
    localparam pmrs_pkg::pmrs_dom_s DOM_ACTIVE = '{
        cpuRun:   1'b1,
        busClkOn: 1'b1,
        coreOn:   1'b1,
        radioOn:  1'b1,
        regsOn:   1'b1,
        ramOn:    1'b1,
        ldoLow:   1'b0,
        lpoOn:    1'b1
    };

    localparam pmrs_pkg::pmrs_dom_s DOM_IDLE = '{
        cpuRun:   1'b0,
        busClkOn: 1'b1,
        coreOn:   1'b1,
        radioOn:  1'b1,
        regsOn:   1'b1,
        ramOn:    1'b1,
        ldoLow:   1'b0,
        lpoOn:    1'b1
    };

    localparam pmrs_pkg::pmrs_dom_s DOM_SLEEP = '{
        cpuRun:   1'b0,
        busClkOn: 1'b0,
        coreOn:   1'b1,
        radioOn:  1'b1,
        regsOn:   1'b1,
        ramOn:    1'b1,
        ldoLow:   1'b1,
        lpoOn:    1'b1
    };

    localparam pmrs_pkg::pmrs_dom_s DOM_PDS = '{
        cpuRun:   1'b0,
        busClkOn: 1'b0,
        coreOn:   1'b0,
        radioOn:  1'b0,
        regsOn:   1'b1,
        ramOn:    1'b1,
        ldoLow:   1'b0,
        lpoOn:    1'b1
    };

    localparam pmrs_pkg::pmrs_dom_s DOM_EXTENDED_POWER_DOWN_SLEEP = '{
        cpuRun:   1'b0,
        busClkOn: 1'b0,
        coreOn:   1'b0,
        radioOn:  1'b0,
        regsOn:   1'b0,
        ramOn:    1'b1,
        ldoLow:   1'b0,
        lpoOn:    1'b1
    };

    // ==========================================================
    // domain control per mode
    always_comb begin
        dom_d = '0;
        case (mode_q)
            pmrs_pkg::PM_ACTIVE: dom_d = DOM_ACTIVE;
            pmrs_pkg::PM_IDLE:   dom_d = DOM_IDLE;
            pmrs_pkg::PM_SLEEP:  dom_d = DOM_SLEEP;
            pmrs_pkg::PM_PDS:    dom_d = DOM_PDS;
            pmrs_pkg::PM_EXTENDED_POWER_DOWN_SLEEP:   dom_d = DOM_EXTENDED_POWER_DOWN_SLEEP;
            pmrs_pkg::PM_OFF:    dom_d = {7'h00, timed_q};
            default:             dom_d = '0;
        endcase
        if (seq_q != SQ_RUN) begin
            dom_d = {8'h00};
        end
    end

    // each clock the sleep logic may gate; all on when awake
    logic [pmrs_pkg::CLK_N-1:0] clkEn_d;
    generate
        for (genvar c = 0; c < pmrs_pkg::CLK_N; c++) begin : g_clk
            assign clkEn_d[c] = (seq_q == SQ_RUN) &
                ((mode_q == pmrs_pkg::PM_ACTIVE) | (mode_q == pmrs_pkg::PM_IDLE) |
                 ((mode_q == pmrs_pkg::PM_SLEEP) & ~clkGateOk[c]));
        end
    endgenerate

    // ==========================================================
    // registers
    always_ff @(posedge clk) begin
        if (hardRst) begin
            seq_q <= SQ_OFF;
        end else begin
            seq_q <= seq_d;
        end
    end

    always_ff @(posedge clk) begin
        if (hardRst | seq_q != SQ_BUCK) begin
            cnt_q <= '0;
        end else if (!cntDone) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (hardRst) begin
            mode_q <= pmrs_pkg::PM_ACTIVE;
            dom_q  <= '0;
            clkEn_q <= '0;
        end else begin
            mode_q <= mode_d;
            dom_q  <= dom_d;
            clkEn_q <= clkEn_d;
        end
    end

    always_ff @(posedge clk) begin
        if (hardRst | applyNow | seq_q != SQ_RUN) begin
            pendV_q <= 1'b0;
            pend_q  <= pmrs_pkg::PM_ACTIVE;
        end else if (reqTake) begin
            pendV_q <= 1'b1;
            pend_q  <= modeReq;
        end
    end

    // timer config captured on entry so it holds through the low-power state
    always_ff @(posedge clk) begin
        if (hardRst) begin
            timed_q <= 1'b0;
            ivl_q   <= '0;
        end else if (applyNow) begin
            timed_q <= offTimedWake;
            ivl_q   <= wakeInterval;
        end
    end

    always_ff @(posedge clk) begin
        if (hardRst | ~lowMode | applyNow) begin
            tmr_q <= '0;
        end else if (tmrArmed & lpoTick & (tmr_q != '1)) begin
            tmr_q <= tmr_q + 1'b1;
        end
    end

    // full init after every core release, including deep off exit
    always_ff @(posedge clk) begin
        if (hardRst | seq_q != SQ_RUN) begin
            init_q <= 1'b1;
        end else if (initDone) begin
            init_q <= 1'b0;
        end
    end

    // ==========================================================
    // outputs
    wire pwrUp = (seq_q != SQ_OFF) & (seq_q != SQ_SHUT);
    assign buckEn     = pwrUp & ~(mode_q == pmrs_pkg::PM_OFF);
    assign ldoRfEn    = ((seq_q == SQ_LDO) | (seq_q == SQ_RUN)) & (mode_q != pmrs_pkg::PM_OFF);
    assign ldoDigEn   = ldoRfEn;
    assign coreRst    = (seq_q != SQ_RUN) | hardRst;
    assign shutdown   = (seq_q == SQ_SHUT);
    assign cpuHalt    = ~dom_q.cpuRun;
    assign busClkEn   = dom_q.busClkOn;
    assign clkEn      = clkEn_q;
    assign radioPwr   = dom_q.radioOn;
    assign corePwr    = dom_q.coreOn;
    assign regsPwr    = dom_q.regsOn;
    assign ramPwr     = dom_q.ramOn;
    assign ldoLowV    = dom_q.ldoLow;
    assign lpoPwr     = dom_q.lpoOn | (mode_q != pmrs_pkg::PM_OFF & seq_q == SQ_RUN);
    assign lpoXtalSel = ~lpoExtClkSel;
    assign curMode    = mode_q;
    assign inInit     = init_q;
endmodule

// File: pmrs_sequencer_assertions.sv
// ==========================================================
// port-level checks for the power sequencer
module pmrs_sequencer_assertions (
    input wire logic                        clk,
    input wire logic                        sys_rst,
    input wire logic                        external_reset_n,
    input wire logic                        brownout,
    input wire logic                        ldoRfStable,
    input wire logic                        ldoDigStable,
    input wire logic                        modeReqValid,
    input wire pmrs_pkg::pmrs_mode_e        modeReq,
    input wire logic                        wait_for_interrupt_state,
    input wire logic [pmrs_pkg::GPIO_N-1:0] gpioWake,
    input wire logic [pmrs_pkg::CLK_N-1:0]  clkGateOk,
    input wire logic                        buckEn,
    input wire logic                        ldoRfEn,
    input wire logic                        ldoDigEn,
    input wire logic                        coreRst,
    input wire logic                        shutdown,
    input wire logic                        cpuHalt,
    input wire logic                        busClkEn,
    input wire logic [pmrs_pkg::CLK_N-1:0]  clkEn,
    input wire logic                        radioPwr,
    input wire logic                        corePwr,
    input wire logic                        ramPwr,
    input wire logic                        ldoLowV,
    input wire pmrs_pkg::pmrs_mode_e        curMode,
    input wire logic                        inInit,
    input wire pmrs_pkg::pmrs_wake_s        wakeCause
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    // ==========================================================
    // sleep entry: request taken, mode set, then domains gated
    sequence sleepReq;
        modeReqValid && modeReq == pmrs_pkg::PM_SLEEP && wait_for_interrupt_state
            && curMode == pmrs_pkg::PM_ACTIVE && !inInit && !coreRst && external_reset_n;
    endsequence
    sequence sleepGated;
        !busClkEn && cpuHalt && ldoLowV && clkEn == ~$past(clkGateOk);
    endsequence

    AST_SLEEP: assert property (
        sleepReq |=> curMode == pmrs_pkg::PM_SLEEP ##1 sleepGated)
        else $error("sleep entry or gating wrong");
    AST_EXTERNAL_RESET_N: assert property (
        !external_reset_n |=> coreRst && !buckEn && !ldoRfEn && !ldoDigEn)
        else $error("external reset not honoured");
    AST_LDO_BUCK: assert property ((ldoRfEn || ldoDigEn) |-> buckEn)
        else $error("ldo on without buck");
    AST_BUCK_TIME: assert property ($rose(ldoRfEn) |-> $past(buckEn, 250))
        else $error("ldo enabled before buck settled");
    AST_CORE_REL: assert property (
        $fell(coreRst) |-> $past(ldoRfStable && ldoDigStable))
        else $error("core released before ldos stable");
    AST_BROWN: assert property (brownout |=> shutdown)
        else $error("brownout without shutdown");
    AST_ACTIVE: assert property (
        curMode == pmrs_pkg::PM_ACTIVE && $past(curMode) == pmrs_pkg::PM_ACTIVE
        && !coreRst && !$past(coreRst) && !shutdown |-> busClkEn && !cpuHalt && (&clkEn))
        else $error("active mode domains wrong");
    AST_IDLE: assert property (
        curMode == pmrs_pkg::PM_IDLE && $past(curMode) == pmrs_pkg::PM_IDLE
        |-> cpuHalt && busClkEn && corePwr && radioPwr && ramPwr)
        else $error("idle mode domains wrong");
    AST_WFI: assert property (
        curMode != pmrs_pkg::PM_ACTIVE && $past(curMode) == pmrs_pkg::PM_ACTIVE
        && $past(external_reset_n) |-> $past(wait_for_interrupt_state))
        else $error("mode left active without wfi");
    AST_GPIO: assert property (
        curMode == pmrs_pkg::PM_SLEEP && (|gpioWake) && external_reset_n
        |=> curMode == pmrs_pkg::PM_ACTIVE && wakeCause.cause == pmrs_pkg::CAUSE_GPIO)
        else $error("gpio wake from sleep missed");
endmodule

// File: tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, sys_rst, external_reset_n, brownout, ldoRfStable, ldoDigStable, lpoExtClkSel;
    logic lpoTick, modeReqValid, offTimedWake, wait_for_interrupt_state, initDone, wakeCauseClr;
    logic buckEn, ldoRfEn, ldoDigEn, coreRst, shutdown, cpuHalt, busClkEn, radioPwr, corePwr;
    logic regsPwr, ramPwr, ldoLowV, lpoPwr, lpoXtalSel, inInit;
    logic [pmrs_pkg::TMR_W-1:0]  wakeInterval;
    logic [pmrs_pkg::GPIO_N-1:0] gpioWake;
    logic [pmrs_pkg::CLK_N-1:0]  clkGateOk, clkEn;
    pmrs_pkg::pmrs_mode_e        modeReq, curMode;
    pmrs_pkg::pmrs_wake_s        wakeCause;
    int                          failures, total_checks;

    pmrs_sequencer dut (.*);

    // ==========================================================
    // helpers
    task automatic ck(logic [31:0] g, logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("wrong value t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic final_report;
        $display("checks=%0d failures=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic req(pmrs_pkg::pmrs_mode_e m);
        @(posedge clk);
        modeReq <= m;
        modeReqValid <= 1'b1;
        wait_for_interrupt_state <= 1'b1;
        @(posedge clk);
        modeReqValid <= 1'b0;
        wait_for_interrupt_state <= 1'b0;
        // domain outputs follow the new mode one edge later
        repeat (2) @(negedge clk);
    endtask
    task automatic gp(logic [pmrs_pkg::GPIO_N-1:0] g);
        @(posedge clk);
        gpioWake <= g;
        @(posedge clk);
        gpioWake <= '0;
        @(negedge clk);
    endtask
    task automatic tick;
        @(posedge clk);
        lpoTick <= 1'b1;
        @(posedge clk);
        lpoTick <= 1'b0;
        @(negedge clk);
    endtask
    task automatic clr;
        @(posedge clk);
        wakeCauseClr <= 1'b1;
        @(posedge clk);
        wakeCauseClr <= 1'b0;
        @(negedge clk);
    endtask
    // margin of two cycles: a wake may be seen a little after buck turned on
    task automatic pwrup;
        int i;
        @(posedge clk);
        ldoRfStable <= 1'b0;
        ldoDigStable <= 1'b0;
        @(negedge clk);
        for (i = 0; i < 400 && buckEn !== 1'b1; i++) @(negedge clk);
        ck(ldoRfEn | ldoDigEn, 1'b0);
        for (i = 0; i < 400 && (ldoRfEn & ldoDigEn) !== 1'b1; i++) @(negedge clk);
        ck(i >= pmrs_pkg::BUCK_CYC - 2, 1'b1);
        repeat (6) @(negedge clk);
        ck(coreRst, 1'b1);
        @(posedge clk);
        ldoRfStable <= 1'b1;
        ldoDigStable <= 1'b1;
        for (i = 0; i < 8 && coreRst !== 1'b0; i++) @(negedge clk);
        ck(coreRst, 1'b0);
        ck(inInit, 1'b1);
        @(posedge clk);
        initDone <= 1'b1;
        @(posedge clk);
        initDone <= 1'b0;
        @(negedge clk);
        ck(inInit, 1'b0);
    endtask

    // ==========================================================
    // scenarios
    task automatic t_idle;
        @(posedge clk);
        modeReq <= pmrs_pkg::PM_IDLE;
        modeReqValid <= 1'b1;
        @(posedge clk);
        modeReqValid <= 1'b0;
        repeat (4) @(negedge clk);
        ck(curMode, pmrs_pkg::PM_ACTIVE);
        @(posedge clk);
        wait_for_interrupt_state <= 1'b1;
        @(posedge clk);
        wait_for_interrupt_state <= 1'b0;
        @(negedge clk);
        ck(curMode, pmrs_pkg::PM_IDLE);
        @(negedge clk);
        ck(cpuHalt & ramPwr & radioPwr, 1'b1);
        gp(20'h00001);
        ck(curMode, pmrs_pkg::PM_ACTIVE);
        clr;
    endtask
    task automatic t_sleep;
        @(posedge clk);
        clkGateOk <= 8'hA5;
        req(pmrs_pkg::PM_SLEEP);
        ck({busClkEn, cpuHalt}, 2'h1);
        ck(clkEn, 8'h5A);
        ck(ldoLowV & ramPwr & regsPwr, 1'b1);
        gp(20'h00208);
        ck(curMode, pmrs_pkg::PM_ACTIVE);
        ck(wakeCause, {1'b0, pmrs_pkg::CAUSE_GPIO, 5'h03});
        clr;
        ck(wakeCause, 8'h00);
    endtask
    task automatic t_timer(pmrs_pkg::pmrs_mode_e m, logic r);
        int k;
        req(m);
        ck({radioPwr, ramPwr, regsPwr}, {2'h1, r});
        for (k = 0; k < 8 && curMode !== pmrs_pkg::PM_ACTIVE; k++) tick;
        ck(k >= 3 && k <= 4, 1'b1);
        ck(wakeCause.cause, pmrs_pkg::CAUSE_TIMER);
        clr;
    endtask
    task automatic t_off(logic timed);
        int i;
        @(posedge clk);
        offTimedWake <= timed;
        req(pmrs_pkg::PM_OFF);
        for (i = 0; i < 50 && buckEn !== 1'b0; i++) @(negedge clk);
        repeat (2) @(negedge clk);
        ck(buckEn | ldoRfEn | ldoDigEn | corePwr | radioPwr, 1'b0);
        ck(lpoPwr, timed);
        if (timed) for (i = 0; i < 8 && buckEn !== 1'b1; i++) tick;
        else gp(20'h00020);
        pwrup;
        ck(wakeCause.fromOff, 1'b1);
        ck(wakeCause.cause, timed ? pmrs_pkg::CAUSE_TIMER : pmrs_pkg::CAUSE_GPIO);
        if (!timed) ck(wakeCause.gpioIdx, 5'h05);
        clr;
    endtask
    task automatic t_external_reset_n;
        req(pmrs_pkg::PM_SLEEP);
        gp(20'h80000);
        @(posedge clk);
        external_reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        external_reset_n <= 1'b1;
        @(negedge clk);
        ck({coreRst, buckEn}, 2'h2);
        ck(wakeCause, {1'b0, pmrs_pkg::CAUSE_GPIO, 5'h13});
        pwrup;
    endtask
    task automatic t_brown;
        @(posedge clk);
        brownout <= 1'b1;
        @(posedge clk);
        brownout <= 1'b0;
        repeat (3) @(negedge clk);
        ck(shutdown, 1'b1);
        ck(wakeCause, 8'h00);
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        pwrup;
    endtask

    // ==========================================================
    // clock, main sequence, watchdog
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        {brownout, ldoRfStable, ldoDigStable, lpoExtClkSel, lpoTick, modeReqValid} = '0;
        {offTimedWake, wait_for_interrupt_state, initDone, wakeCauseClr} = '0;
        {failures, total_checks} = '0;
        sys_rst = 1'b1;
        external_reset_n = 1'b1;
        modeReq = pmrs_pkg::PM_ACTIVE;
        wakeInterval = 32'h00000003;
        gpioWake = '0;
        clkGateOk = 8'hFF;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        pwrup;
        ck(lpoXtalSel, 1'b1);
        @(posedge clk);
        lpoExtClkSel <= 1'b1;
        @(negedge clk);
        ck(lpoXtalSel, 1'b0);
        ck(busClkEn & ~cpuHalt & (&clkEn), 1'b1);
        t_idle;
        t_sleep;
        t_timer(pmrs_pkg::PM_PDS, 1'b1);
        t_timer(pmrs_pkg::PM_EXTENDED_POWER_DOWN_SLEEP, 1'b0);
        t_off(1'b0);
        t_off(1'b1);
        t_external_reset_n;
        t_brown;
        final_report;
    end
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        final_report;
    end
endmodule

bind pmrs_sequencer pmrs_sequencer_assertions chk (.*);
